// File: core/exec_slice_cfg.svh
// constants and reset values of the instruction execution slice
// Function
// - trap pushes next address, loads program counter 0x001, three cycles
// - or-immediate ORs accumulator with constant, sets zero flag, one cycle
// - or-register ORs accumulator with register; destination bit picks target
// - special-page store copies accumulator into indexed control register
// - special-page read copies indexed control register into accumulator
// - long jump loads ten-bit target into program counter, two cycles
// - long call pushes next address, loads ten-bit target, two cycles
// - push writes current stack level, then pointer advances by one
// - accumulator move writes register, flags and accumulator unchanged
// - skipped instruction is discarded and runs as one no-operation
`ifndef EXEC_SLICE_CFG_SVH
`define EXEC_SLICE_CFG_SVH

// ----------------------------------------------------------------
// vectors and reset values
// ----------------------------------------------------------------
`define TRAP_VECTOR   10'h001
`define PC_RESET      10'h000
`define ACC_RESET     8'h00

// ----------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------
`define TRAP_CYCLES   3
`define LONG_CYCLES   2

`endif

// File: core/exec_slice_pkg.sv
// types shared by the instruction execution slice
package exec_slice_pkg;

  // decoded operation presented to the slice
  typedef enum logic [3:0] {
    nop_op                = 4'h0,
    trap_op               = 4'h1,
    or_immediate_op       = 4'h2,
    or_register_op        = 4'h3,
    special_page_store_op = 4'h4,
    special_page_read_op  = 4'h5,
    long_jump_op          = 4'h6,
    long_call_op          = 4'h7,
    acc_to_reg_move_op    = 4'h8
  } op_e;

endpackage

// File: core/mcu_instruction_exec_slice.sv
// execution slice: or ops, special page, long jump and call, trap
`timescale 1ns/10ps
`default_nettype none
`include "exec_slice_cfg.svh"

module mcu_instruction_exec_slice
  import exec_slice_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int NUM_REGS    = 64,
  parameter int NUM_SPR     = 16
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  // decoded instruction from fetch
  input  wire logic                  instr_valid_i,
  input  wire op_e                   op_i,
  input  wire logic [9:0]            imm_i,
  input  wire logic [5:0]            reg_addr_i,
  input  wire logic                  dest_i,
  input  wire logic [3:0]            spr_idx_i,
  input  wire logic                  skip_i,
  // core state
  output logic                       ready_o,
  output logic                       retired_o,
  output logic [7:0]                 accumulator_o,
  output logic                       zero_o,
  output logic [9:0]                 pc_o,
  output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr_o,
  // data register write echo
  output logic                       reg_wr_o,
  output logic [5:0]                 reg_wr_addr_o,
  output logic [7:0]                 reg_wr_data_o,
  // special page control registers
  output logic [NUM_SPR*8-1:0]       special_page_control_reg_o
);

  // ----------------------------------------------------------------
  // sizes and wait counts
  // ----------------------------------------------------------------
  // stack pointer width; the depth must be a power of two so that
  // the pointer wraps exactly after the last entry
  localparam int SPW = $clog2(STACK_DEPTH);
  // wait states after the taking edge, one less than the length
  localparam logic [1:0] TRAP_WAIT = 2'(`TRAP_CYCLES - 1);
  localparam logic [1:0] LONG_WAIT = 2'(`LONG_CYCLES - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // architectural state
    logic [7:0]                  accumulator;
    logic                        zero;
    logic [9:0]                  pc;
    // return stack and storage
    logic [SPW-1:0]              sp;
    logic [STACK_DEPTH-1:0][9:0] stack;
    logic [NUM_REGS-1:0][7:0]    regs;
    logic [NUM_SPR-1:0][7:0]     spr;
    // sequencing
    logic [1:0]                  wait_cnt;
    logic                        skip_pend;
    logic                        ready;
    logic                        retired;
    // data register write echo
    logic                        reg_wr;
    logic [5:0]                  reg_wr_addr;
    logic [7:0]                  reg_wr_data;
  } state_s;

  // reset: idle and ready, all storage cleared
  localparam state_s STATE_RESET = '{
    accumulator: `ACC_RESET,
    pc:          `PC_RESET,
    ready:       1'b1,
    default:     '0
  };

  // ----------------------------------------------------------------
  // registers and shared datapath
  // ----------------------------------------------------------------
  state_s         s_r;
  state_s         s_nxt;
  logic [7:0]     or_res;
  logic [9:0]     pc_inc;
  logic [SPW-1:0] sp_inc;

  // return address, wraps at the top of program space
  assign pc_inc = 10'(s_r.pc + 10'h001);

  // push pointer wraps at the depth, overflow overwrites the oldest
  assign sp_inc = SPW'(s_r.sp + 1'b1);

  // or source: constant for the immediate form, data register otherwise
  assign or_res = (op_i == or_immediate_op) ?
                  (s_r.accumulator | imm_i[7:0]) :
                  (s_r.accumulator | s_r.regs[reg_addr_i]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    // state holds by default, the pulses drop after one cycle
    s_nxt         = s_r;
    s_nxt.retired = 1'b0;
    s_nxt.reg_wr  = 1'b0;

    // skip request latched, a new request wins over consumption
    if (skip_i) begin
      s_nxt.skip_pend = 1'b1;
    end

    // multi-cycle op in flight: requests are refused until it ends
    if (s_r.wait_cnt != 2'h0) begin
      s_nxt.wait_cnt = s_r.wait_cnt - 2'h1;
    end else if (instr_valid_i) begin
      s_nxt.retired = 1'b1;
      s_nxt.pc      = pc_inc;
      if (s_r.skip_pend) begin
        // fetched instruction discarded, behaves as nop
        s_nxt.skip_pend = skip_i;
      end else begin
        case (op_i)
          // software trap: push return address, enter the trap vector
          trap_op: begin
            s_nxt.stack[s_r.sp] = pc_inc;
            s_nxt.sp            = sp_inc;
            s_nxt.pc            = `TRAP_VECTOR;
            s_nxt.wait_cnt      = TRAP_WAIT;
          end

          // or with the constant, result always to the accumulator
          or_immediate_op: begin
            s_nxt.accumulator = or_res;
            s_nxt.zero        = (or_res == 8'h00);
          end

          // or with a data register, destination bit picks the target
          or_register_op: begin
            s_nxt.zero = (or_res == 8'h00);
            if (dest_i) begin
              s_nxt.regs[reg_addr_i] = or_res;
              s_nxt.reg_wr           = 1'b1;
              s_nxt.reg_wr_addr      = reg_addr_i;
              s_nxt.reg_wr_data      = or_res;
            end else begin
              s_nxt.accumulator = or_res;
            end
          end

          // special page store, flags untouched
          special_page_store_op: begin
            s_nxt.spr[spr_idx_i] = s_r.accumulator;
          end

          // special page read, source register kept, flags untouched
          special_page_read_op: begin
            s_nxt.accumulator = s_r.spr[spr_idx_i];
          end

          // long jump: stack and flags untouched
          long_jump_op: begin
            s_nxt.pc       = imm_i;
            s_nxt.wait_cnt = LONG_WAIT;
          end

          // long call: push return address, then load the target
          long_call_op: begin
            s_nxt.stack[s_r.sp] = pc_inc;
            s_nxt.sp            = sp_inc;
            s_nxt.pc            = imm_i;
            s_nxt.wait_cnt      = LONG_WAIT;
          end

          // accumulator copied into a data register, flags untouched
          acc_to_reg_move_op: begin
            s_nxt.regs[reg_addr_i] = s_r.accumulator;
            s_nxt.reg_wr           = 1'b1;
            s_nxt.reg_wr_addr      = reg_addr_i;
            s_nxt.reg_wr_data      = s_r.accumulator;
          end

          // nop and unused codes only advance the program counter
          default: begin
            s_nxt.pc = pc_inc; // unknown codes act as nop
          end
        endcase
      end
    end

    // ready again once the last wait state has passed
    s_nxt.ready = (s_nxt.wait_cnt == 2'h0);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_r <= STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // outputs taken straight from the state register
  assign ready_o                    = s_r.ready;
  assign retired_o                  = s_r.retired;
  assign accumulator_o              = s_r.accumulator;
  assign zero_o                     = s_r.zero;
  assign pc_o                       = s_r.pc;
  assign stack_ptr_o                = s_r.sp;
  assign reg_wr_o                   = s_r.reg_wr;
  assign reg_wr_addr_o              = s_r.reg_wr_addr;
  assign reg_wr_data_o              = s_r.reg_wr_data;

  // control registers flattened, entry k on bits 8k+7 down to 8k
  for (genvar k = 0; k < NUM_SPR; k++) begin : g_spr_out
    assign special_page_control_reg_o[k*8 +: 8] = s_r.spr[k];
  end

endmodule
`default_nettype wire

// File: dv/exec_slice_properties.sv
// assertion checker for the execution slice ports
`timescale 1ns/10ps
`default_nettype none
module exec_slice_properties
  import exec_slice_pkg::*;
#(parameter int STACK_DEPTH = 8) (
  input wire logic                          ref_clk_i,
  input wire logic                          reset_i,
  input wire logic                          instr_valid_i,
  input wire op_e                           op_i,
  input wire logic [9:0]                    imm_i,
  input wire logic                          skip_i,
  input wire logic                          ready_o,
  input wire logic                          retired_o,
  input wire logic [7:0]                    accumulator_o,
  input wire logic                          zero_o,
  input wire logic [9:0]                    pc_o,
  input wire logic [$clog2(STACK_DEPTH)-1:0] stack_ptr_o,
  input wire logic                          reg_wr_o,
  input wire logic [7:0]                    reg_wr_data_o
);
  logic arm_r;
  wire  tk = instr_valid_i && ready_o && !arm_r;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // skip stays armed until the next taken instruction
  always_ff @(posedge ref_clk_i)
    arm_r <= !reset_i && (skip_i || (arm_r && !(instr_valid_i && ready_o)));
  chk_trap_vector: assert property (
    tk && op_i == trap_op |=> pc_o == 10'h001) else $error("trap vector");
  chk_trap_stall: assert property (
    tk && op_i == trap_op |=> !ready_o ##1 !ready_o ##1 ready_o)
    else $error("trap length");
  chk_jump_load: assert property (
    tk && op_i == long_jump_op |=> pc_o == $past(imm_i) && !ready_o
    && $stable(stack_ptr_o) ##1 ready_o) else $error("jump");
  chk_call_push: assert property (
    tk && op_i == long_call_op |=> pc_o == $past(imm_i)
    && stack_ptr_o == $past(stack_ptr_o) + 1'b1) else $error("call");
  chk_or_const: assert property (
    tk && op_i == or_immediate_op |=> accumulator_o == ($past(accumulator_o)
    | $past(imm_i[7:0])) && zero_o == (accumulator_o == 8'h00))
    else $error("or const");
  chk_move_hold: assert property (
    tk && op_i == acc_to_reg_move_op |=> reg_wr_o && $stable(zero_o)
    && reg_wr_data_o == $past(accumulator_o) && $stable(accumulator_o))
    else $error("move");
  chk_one_cycle: assert property (
    tk && op_i inside {or_register_op, acc_to_reg_move_op} |=> ready_o
    && retired_o) else $error("one cycle");
  chk_skip_nop: assert property (
    instr_valid_i && ready_o && arm_r |=> pc_o == $past(pc_o) + 10'h001
    && !reg_wr_o && $stable(accumulator_o)) else $error("skip");
  cov_trap: cover property (tk && op_i == trap_op);
  cov_call: cover property (tk && op_i == long_call_op);
  cov_skip: cover property (instr_valid_i && ready_o && arm_r);
endmodule
`default_nettype wire

// File: dv/mcu_instruction_exec_slice_tb.sv
// self-checking bench for the execution slice
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_exec_slice_tb;
  import exec_slice_pkg::*;
  logic ref_clk_i = 0, reset_i = 1, instr_valid_i = 0, dest_i = 0, skip_i = 0;
  op_e op_i = nop_op;
  logic [9:0] imm_i = '0, pc_o;
  logic [5:0] reg_addr_i = '0, reg_wr_addr_o;
  logic [3:0] spr_idx_i = '0;
  logic ready_o, retired_o, zero_o, reg_wr_o;
  logic [7:0] accumulator_o, reg_wr_data_o;
  logic [2:0] stack_ptr_o;
  logic [127:0] special_page_control_reg_o;
  int num_errors = 0, samples_checked = 0;
  mcu_instruction_exec_slice dut (
    .ref_clk_i                  (ref_clk_i),
    .reset_i                    (reset_i),
    .instr_valid_i              (instr_valid_i),
    .op_i                       (op_i),
    .imm_i                      (imm_i),
    .reg_addr_i                 (reg_addr_i),
    .dest_i                     (dest_i),
    .spr_idx_i                  (spr_idx_i),
    .skip_i                     (skip_i),
    .ready_o                    (ready_o),
    .retired_o                  (retired_o),
    .accumulator_o              (accumulator_o),
    .zero_o                     (zero_o),
    .pc_o                       (pc_o),
    .stack_ptr_o                (stack_ptr_o),
    .reg_wr_o                   (reg_wr_o),
    .reg_wr_addr_o              (reg_wr_addr_o),
    .reg_wr_data_o              (reg_wr_data_o),
    .special_page_control_reg_o (special_page_control_reg_o)
  );
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge ref_clk_i);
    #2;
  endtask
  // present one instruction and pass its taking edge
  task automatic issue(op_e o, logic [9:0] im, logic [5:0] ra = '0,
                       logic d = 0, logic [3:0] si = '0, bit hold = 0);
    for (int n = 0; n < 4 && ready_o !== 1'b1; n++) tick;
    op_i = o;
    imm_i = im;
    reg_addr_i = ra;
    dest_i = d;
    spr_idx_i = si;
    if (instr_valid_i !== 1'b1) instr_valid_i = 1;
    tick;
    instr_valid_i = hold;
  endtask
  task automatic t_logic;
    issue(or_immediate_op, 10'h000);
    chk(zero_o, 1);
    issue(or_immediate_op, 10'h0aa, .hold(1));
    issue(or_immediate_op, 10'h050);
    chk({ready_o, retired_o, zero_o, accumulator_o}, 11'h6fa);
    issue(acc_to_reg_move_op, 10'h000, 6'h3f);
    chk({reg_wr_o, reg_wr_addr_o, reg_wr_data_o, accumulator_o}, 23'h7f_fafa);
    issue(special_page_read_op, 10'h000, .si(4'hf));
    chk({accumulator_o, zero_o}, 9'h000);
    issue(or_register_op, 10'h000, 6'h3f);
    chk({reg_wr_o, accumulator_o, zero_o}, 10'h1f4);
    issue(special_page_store_op, 10'h000, .si(4'hf));
    chk(special_page_control_reg_o[127:120], 8'hfa);
    issue(or_register_op, 10'h000, 6'h3f, 1);
    chk({reg_wr_o, reg_wr_data_o, accumulator_o}, 17'h1_fafa);
    // register 1 gets 0x05, then an or into it must leave the acc alone
    issue(special_page_read_op, 10'h000, .si(4'h0));
    issue(or_immediate_op, 10'h005);
    issue(acc_to_reg_move_op, 10'h000, 6'h01);
    issue(special_page_read_op, 10'h000, .si(4'hf));
    chk({accumulator_o, special_page_control_reg_o[127:120]}, 16'hfafa);
    issue(or_register_op, 10'h000, 6'h01, 1);
    chk({reg_wr_o, reg_wr_data_o, accumulator_o}, 17'h1_fffa);
  endtask
  task automatic t_flow;
    logic [2:0] sp0;
    sp0 = stack_ptr_o;
    issue(long_jump_op, 10'h3ff);
    chk({ready_o, pc_o, stack_ptr_o}, {1'b0, 10'h3ff, sp0});
    for (int k = 1; k <= 8; k++) begin
      issue(long_call_op, 10'h155);
      chk({pc_o, stack_ptr_o}, {10'h155, 3'(sp0 + k)});
    end
    issue(trap_op, 10'h000);
    chk({ready_o, pc_o}, 11'h001);
    tick;
    chk(ready_o, 0);
    tick;
    chk({ready_o, stack_ptr_o}, {1'b1, 3'(sp0 + 1)});
  endtask
  // armed skip turns the next taken instruction into a no-operation
  // a skip held over the discarding edge re-arms for one more discard
  task automatic t_skip;
    logic [9:0] pc0;
    pc0 = pc_o;
    skip_i = 1;
    tick;
    issue(or_immediate_op, 10'h005);
    skip_i = 0;
    chk({pc_o, accumulator_o}, {pc0 + 10'h001, 8'hfa});
    issue(or_immediate_op, 10'h005);
    chk({pc_o, accumulator_o}, {pc0 + 10'h002, 8'hfa});
    issue(or_immediate_op, 10'h005);
    chk({pc_o, accumulator_o}, {pc0 + 10'h003, 8'hff});
  endtask
  // nop only advances; a mid-run reset restores the idle state
  task automatic t_reset;
    logic [9:0] pc0;
    pc0 = pc_o;
    issue(nop_op, 10'h3c3);
    chk({pc_o, accumulator_o, reg_wr_o}, {pc0 + 10'h001, 8'hff, 1'b0});
    reset_i = 1;
    tick;
    tick;
    chk({ready_o, retired_o, pc_o, stack_ptr_o}, {2'b10, 13'h0000});
    reset_i = 0;
    issue(or_immediate_op, 10'h011);
    chk({pc_o, accumulator_o, zero_o}, {10'h001, 8'h11, 1'b0});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (5) tick;
    reset_i = 0;
    t_logic;
    t_flow;
    t_skip;
    t_reset;
    tally_and_finish;
  end
endmodule
bind mcu_instruction_exec_slice exec_slice_properties #(
  .STACK_DEPTH (STACK_DEPTH)
) u_chk (
  .ref_clk_i     (ref_clk_i),
  .reset_i       (reset_i),
  .instr_valid_i (instr_valid_i),
  .op_i          (op_i),
  .imm_i         (imm_i),
  .skip_i        (skip_i),
  .ready_o       (ready_o),
  .retired_o     (retired_o),
  .accumulator_o (accumulator_o),
  .zero_o        (zero_o),
  .pc_o          (pc_o),
  .stack_ptr_o   (stack_ptr_o),
  .reg_wr_o      (reg_wr_o),
  .reg_wr_data_o (reg_wr_data_o)
);
`default_nettype wire
